// [verilog/dais_pkg.sv]
// Constants shared by the discrete alarm input scanner.
package dais_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SECOND_NS     = 1_000_000_000;
    localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned MAX_DELAY_H   = 18;
    localparam int unsigned MAX_DELAY_S   = MAX_DELAY_H * 3600;

    // ==========================================================
    // Sizes
    localparam int unsigned POINTS_MAX    = 32;
    localparam int unsigned DETAIL_COUNT  = 15;
    localparam int unsigned DELAY_W       = 16;
    localparam int unsigned ADR_W         = 8;

    // ==========================================================
    // Register word indices (byte address is four times the index)
    localparam logic [5:0] IDX_CTRL     = 6'h00;
    localparam logic [5:0] IDX_POLARITY = 6'h01;
    localparam logic [5:0] IDX_KIND     = 6'h02;
    localparam logic [5:0] IDX_IMAGE    = 6'h03;
    localparam logic [5:0] IDX_SUMMARY  = 6'h04;
    localparam logic [5:0] IDX_QUAL     = 6'h05;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h06;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h07;
    localparam logic [5:0] IDX_DELAY0   = 6'h20;

    // ==========================================================
    // Control register fields
    localparam int unsigned CTRL_DEST_LSB = 0;
    localparam int unsigned CTRL_DEST_W   = 4;
    localparam int unsigned CTRL_SPT_LSB  = 4;
    localparam int unsigned CTRL_SPT_W    = 5;
    localparam int unsigned CTRL_NONE_BIT = 9;
    localparam int unsigned CTRL_TRIP_BIT = 10;
    localparam int unsigned CTRL_W        = 11;
    localparam logic [3:0]  DEST_SUMMARY  = 4'h0;

    // ==========================================================
    // Reset values
    localparam logic [10:0] CTRL_RESET     = 11'h200;
    localparam logic [31:0] POLARITY_RESET = 32'h0000_0000;
    localparam logic [31:0] KIND_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [15:0] DELAY_RESET    = 16'h0000;

endpackage

// [verilog/dais_point_qual.sv]
// One input point: synchroniser, polarity and delay qualification.
`timescale 1ns/1ps
module dais_point_qual
(
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         contact_i,
    input  wire logic                         invert_i,
    input  wire logic                         tick_i,
    input  wire logic [dais_pkg::DELAY_W-1:0] delay_i,
    output logic                              qual_o
);
    import dais_pkg::*;

    logic                 sync1;
    logic                 sync2;
    logic [DELAY_W:0]     secs;
    logic [DELAY_W:0]     next_secs;
    logic                 next_qual;
    logic                 asserted;

    // ==========================================================
    // Qualification
    always_comb
    begin
        asserted  = sync2 ^ invert_i;
        next_secs = secs;
        next_qual = 1'b0;
        if (!asserted)
        begin
            next_secs = '0;
        end
        else if (tick_i && secs <= {1'b0, delay_i})
        begin
            next_secs = secs + 1'b1;
        end
        // Qualified once more than the delay in whole seconds has passed.
        if (asserted && (delay_i == '0 || secs > {1'b0, delay_i}))
        begin
            next_qual = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1  <= 1'b0;
            sync2  <= 1'b0;
            secs   <= '0;
            qual_o <= 1'b0;
        end
        else
        begin
            sync1  <= contact_i;
            sync2  <= sync1;
            secs   <= next_secs;
            qual_o <= next_qual;
        end
    end

endmodule

// [verilog/dais_scanner.sv]
// Discrete alarm input scanner with Wishbone register access.
`timescale 1ns/1ps
module dais_scanner
#(
    parameter int NUM_POINTS  = 32,
    parameter int TICK_CYCLES = int'(dais_pkg::TICK_CYCLES)
)
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [dais_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic [NUM_POINTS-1:0]      contact_i,
    output logic                            relay_o,
    output logic                            irq_o
);
    import dais_pkg::*;

    // ==========================================================
    // Elaboration checks
    generate
        if (NUM_POINTS < 1 || NUM_POINTS > int'(POINTS_MAX))
        begin : g_bad_points
            $error("NUM_POINTS must lie between 1 and 32");
        end
        if (TICK_CYCLES < 2)
        begin : g_bad_tick
            $error("TICK_CYCLES must be at least 2");
        end
    endgenerate

    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_delay(input logic [5:0] i);
        return i >= IDX_DELAY0;
    endfunction

    function automatic logic [31:0] one_hot(input logic [4:0] pos);
        logic [31:0] res;
        res      = 32'h0000_0000;
        res[pos] = 1'b1;
        return res;
    endfunction

    // ==========================================================
    // Register state
    logic [CTRL_W-1:0]  ctrl;
    logic [CTRL_W-1:0]  next_ctrl;
    logic [31:0]        polarity;
    logic [31:0]        next_polarity;
    logic [31:0]        kind;
    logic [31:0]        next_kind;
    logic [31:0]        irq_mask;
    logic [31:0]        next_irq_mask;
    logic [DELAY_W-1:0] delay_q      [0:POINTS_MAX-1];
    logic [DELAY_W-1:0] next_delay_q [0:POINTS_MAX-1];
    logic [31:0]        next_dat;
    logic               next_ack;

    // ==========================================================
    // Point state
    logic [31:0]        qual;
    logic [31:0]        latch;
    logic [31:0]        next_latch;
    logic [31:0]        irq_stat;
    logic [31:0]        next_irq_stat;
    logic               next_relay;
    logic               next_irq;
    logic [31:0]        image;
    logic [31:0]        summary_img;
    logic [31:0]        alarm_qual;
    logic               alarm_any;

    // ==========================================================
    // Bus decode
    logic               take;
    logic               poll;
    logic               wr_stat;
    logic [5:0]         idx;
    logic [3:0]         dest;
    logic [4:0]         spt;

    assign idx     = wb_adr_i[ADR_W-1:2];
    assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign poll    = take && !wb_we_i && idx == IDX_IMAGE;
    assign wr_stat = take && wb_we_i && idx == IDX_IRQ_STAT;
    assign dest    = ctrl[CTRL_DEST_LSB +: CTRL_DEST_W];
    assign spt     = ctrl[CTRL_SPT_LSB +: CTRL_SPT_W];

    // ==========================================================
    // One-second tick
    // Thirty-two bits hold a full second of clocks at any sensible rate.
    logic [31:0]        tick_cnt;
    logic [31:0]        next_tick_cnt;
    logic               tick;
    logic               next_tick;

    always_comb
    begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 32'h0000_0001;
        if (tick_cnt == 32'(TICK_CYCLES - 1))
        begin
            next_tick_cnt = 32'h0000_0000;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // ==========================================================
    // Per-point qualifiers
    genvar gi;
    generate
        for (gi = 0; gi < int'(POINTS_MAX); gi++)
        begin : g_point
            if (gi < NUM_POINTS)
            begin : g_used
                dais_point_qual u_qual
                (
                    .clk_i     (clk_i),
                    .rst_i     (rst_i),
                    .contact_i (contact_i[gi]),
                    .invert_i  (polarity[gi]),
                    .tick_i    (tick),
                    .delay_i   (delay_q[gi]),
                    .qual_o    (qual[gi])
                );
            end
            else
            begin : g_unused
                assign qual[gi] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // Images
    always_comb
    begin
        alarm_qual  = qual & ~kind;
        image       = (latch & ~kind) | (qual & kind);
        alarm_any   = |(latch & ~kind);
        summary_img = 32'h0000_0000;
        if (dest == DEST_SUMMARY)
        begin
            summary_img = image;
        end
        else if (!ctrl[CTRL_NONE_BIT] && alarm_any)
        begin
            summary_img = one_hot(spt);
        end
    end

    // ==========================================================
    // Latches, interrupt and relay
    always_comb
    begin
        // An image read clears only the bits whose input has already dropped,
        // because the qualified level re-sets them in the same step.
        next_latch = alarm_qual;
        if (!poll)
        begin
            next_latch = next_latch | (latch & ~kind);
        end
        // A new event wins over a simultaneous write-one-to-clear.
        next_irq_stat = irq_stat;
        if (wr_stat)
        begin
            next_irq_stat = irq_stat & ~merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
        end
        next_irq_stat = next_irq_stat | (alarm_qual & ~latch);
        next_irq      = |(irq_stat & irq_mask);
        next_relay    = ctrl[CTRL_TRIP_BIT] && alarm_any;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            latch    <= 32'h0000_0000;
            irq_stat <= 32'h0000_0000;
            irq_o    <= 1'b0;
            relay_o  <= 1'b0;
        end
        else
        begin
            latch    <= next_latch;
            irq_stat <= next_irq_stat;
            irq_o    <= next_irq;
            relay_o  <= next_relay;
        end
    end

    // ==========================================================
    // Wishbone register file
    always_comb
    begin
        logic [31:0] wv;
        logic [4:0]  di;
        wv            = 32'h0000_0000;
        di            = idx[4:0];
        next_ctrl     = ctrl;
        next_polarity = polarity;
        next_kind     = kind;
        next_irq_mask = irq_mask;
        for (int i = 0; i < int'(POINTS_MAX); i++)
        begin
            next_delay_q[i] = delay_q[i];
        end
        next_ack = take;
        next_dat = 32'h0000_0000;
        if (take && wb_we_i)
        begin
            case (idx)
                IDX_CTRL:
                begin
                    wv        = merge_bytes({21'h000000, ctrl}, wb_dat_i, wb_sel_i);
                    next_ctrl = wv[CTRL_W-1:0];
                end
                IDX_POLARITY: next_polarity = merge_bytes(polarity, wb_dat_i, wb_sel_i);
                IDX_KIND:     next_kind     = merge_bytes(kind, wb_dat_i, wb_sel_i);
                IDX_IRQ_MASK: next_irq_mask = merge_bytes(irq_mask, wb_dat_i, wb_sel_i);
                default:
                begin
                    if (is_delay(idx))
                    begin
                        wv = merge_bytes({16'h0000, delay_q[di]}, wb_dat_i, wb_sel_i);
                        // Values beyond eighteen hours are held at the limit.
                        if (wv > 32'(MAX_DELAY_S))
                        begin
                            wv = 32'(MAX_DELAY_S);
                        end
                        next_delay_q[di] = wv[DELAY_W-1:0];
                    end
                end
            endcase
        end
        else if (take)
        begin
            case (idx)
                IDX_CTRL:     next_dat = {21'h000000, ctrl};
                IDX_POLARITY: next_dat = polarity;
                IDX_KIND:     next_dat = kind;
                IDX_IMAGE:    next_dat = image;
                IDX_SUMMARY:  next_dat = summary_img;
                IDX_QUAL:     next_dat = qual;
                IDX_IRQ_STAT: next_dat = irq_stat;
                IDX_IRQ_MASK: next_dat = irq_mask;
                default:
                begin
                    if (is_delay(idx))
                    begin
                        next_dat = {16'h0000, delay_q[di]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl     <= CTRL_RESET;
            polarity <= POLARITY_RESET;
            kind     <= KIND_RESET;
            irq_mask <= MASK_RESET;
            for (int i = 0; i < int'(POINTS_MAX); i++)
            begin
                delay_q[i] <= DELAY_RESET;
            end
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ctrl     <= next_ctrl;
            polarity <= next_polarity;
            kind     <= next_kind;
            irq_mask <= next_irq_mask;
            for (int i = 0; i < int'(POINTS_MAX); i++)
            begin
                delay_q[i] <= next_delay_q[i];
            end
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

endmodule

// [verif/dais_scanner_properties.sv]
// Concurrent checks on the scanner's bus, relay and interrupt outputs.
`timescale 1ns/1ps
module dais_scanner_chk
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        relay_o,
    input wire logic        irq_o
);
    // ==========================================================
    // Cycles since the last acknowledge
    // Relay and interrupt may only drop as a result of a bus access.
    logic [3:0] ack_age;
    logic [3:0] next_ack_age;

    always_comb next_ack_age = wb_ack_o ? 4'h0 : ((ack_age == 4'hF) ? ack_age : ack_age + 4'h1);
    always_ff @(posedge clk_i) ack_age <= rst_i ? 4'hF : next_ack_age;

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("acknowledge without a request");
    ack_alternate_a: assert property (wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i)
        |-> wb_ack_o != $past(wb_ack_o))
        else $error("held strobe not answered every other cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data driven outside acknowledge");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !relay_o && !irq_o)
        else $error("outputs active right after reset");
    relay_hold_a: assert property ($fell(relay_o) |-> ack_age < 4'h6)
        else $error("relay opened without a poll or write");
    irq_hold_a: assert property ($fell(irq_o) |-> ack_age < 4'h6)
        else $error("interrupt dropped without a write");
endmodule

bind dais_scanner dais_scanner_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .relay_o(relay_o),
    .irq_o(irq_o));

// [verif/dais_poll_master.sv]
// Polling master model: classic Wishbone single cycles into the scanner.
`timescale 1ns/1ps
module dais_poll_master
(
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [7:0]       wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o
);
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // The request stands until ack is seen; released address and data lines show inverted
    // values so that a design reading them late cannot pass by accident.
    // No cycle limit here: only the bench's own timeout may end a wait.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_adr_o <= ~a;
        wb_dat_o <= ~d;
    endtask
endmodule

// [verif/tb_top.sv]
// Self-checking testbench for the discrete alarm input scanner.
`timescale 1ns/1ps
module tb_top;
    import dais_pkg::*;
    localparam int TICK = 8;

    logic        clk_i;
    logic        rst_i;
    logic [31:0] contact;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        relay_o;
    logic        irq_o;
    logic [31:0] q;
    int          failures;
    int          check_count;
    int          cycles;

    dais_poll_master pm (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

    dais_scanner #(.NUM_POINTS(32), .TICK_CYCLES(TICK)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .contact_i(contact),
        .relay_o(relay_o), .irq_o(irq_o));

    // ==========================================================
    // Clock, reset and timeout
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            stop_test();
        end
    end

    // ==========================================================
    // Access and compare tasks
    function automatic logic [7:0] ad(input logic [5:0] i);
        return {i, 2'b00};
    endfunction

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        pm.xfer(1'b1, ad(i), 4'hF, d, q);
    endtask

    task automatic wrs(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s);
        pm.xfer(1'b1, ad(i), s, d, q);
    endtask

    task automatic rdc(input logic [5:0] i, input logic [31:0] e);
        pm.xfer(1'b0, ad(i), 4'hF, 32'h0000_0000, q);
        check_count++;
        if (q !== e)
        begin
            failures++;
            $display("Error at %0t: expected %h got %h", $time, e, q);
        end
    endtask

    task automatic chkb(input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic setc(input int n, input logic v);
        @(posedge clk_i);
        contact[n] <= v;
    endtask

    task automatic pulse(input int n, input int len);
        setc(n, 1'b1);
        repeat (len) @(posedge clk_i);
        setc(n, 1'b0);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        failures = 0;
        check_count = 0;
        cycles = 0;
        contact = 32'h0000_0000;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(IDX_CTRL, {21'h0, CTRL_RESET});
        rdc(IDX_POLARITY, POLARITY_RESET);
        rdc(IDX_KIND, KIND_RESET);
        rdc(IDX_IRQ_MASK, MASK_RESET);
        rdc(IDX_DELAY0, {16'h0, DELAY_RESET});
        wr(6'h10, 32'hFFFF_FFFF);
        rdc(6'h10, 32'h0000_0000);
        wrs(IDX_IRQ_MASK, 32'h1234_5678, 4'h5);
        rdc(IDX_IRQ_MASK, 32'h0034_0078);
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        $display("test reset done");

        wr(IDX_CTRL, 32'h0000_0400);
        pulse(5, 6);
        chkb(1'b1, relay_o);
        chkb(1'b0, irq_o);
        rdc(IDX_IRQ_STAT, 32'h0000_0020);
        wr(IDX_IRQ_MASK, 32'h0000_0020);
        repeat (4) @(posedge clk_i);
        chkb(1'b1, irq_o);
        rdc(IDX_SUMMARY, 32'h0000_0020);
        rdc(IDX_IMAGE, 32'h0000_0020);
        repeat (4) @(posedge clk_i);
        chkb(1'b0, relay_o);
        rdc(IDX_IMAGE, 32'h0000_0000);
        chkb(1'b1, irq_o);
        wr(IDX_IRQ_STAT, 32'h0000_0020);
        repeat (4) @(posedge clk_i);
        chkb(1'b0, irq_o);
        rdc(IDX_IRQ_STAT, 32'h0000_0000);
        $display("test summary alarm done");

        wr(IDX_POLARITY, 32'h0000_0080);
        repeat (6) @(posedge clk_i);
        rdc(IDX_QUAL, 32'h0000_0080);
        setc(7, 1'b1);
        repeat (6) @(posedge clk_i);
        rdc(IDX_QUAL, 32'h0000_0000);
        rdc(IDX_IMAGE, 32'h0000_0080);
        // Contact first: it reaches the qualifier two edges later, together
        // with the polarity write, so point 7 never looks asserted between.
        setc(7, 1'b0);
        wr(IDX_POLARITY, 32'h0000_0000);
        $display("test polarity done");

        wr(IDX_KIND, 32'h0000_0004);
        wr(IDX_CTRL, 32'h0000_0493);
        setc(2, 1'b1);
        repeat (6) @(posedge clk_i);
        rdc(IDX_IMAGE, 32'h0000_0004);
        rdc(IDX_SUMMARY, 32'h0000_0000);
        chkb(1'b0, relay_o);
        setc(2, 1'b0);
        repeat (6) @(posedge clk_i);
        rdc(IDX_IMAGE, 32'h0000_0000);
        pulse(4, 6);
        rdc(IDX_SUMMARY, 32'h0000_0200);
        rdc(IDX_IMAGE, 32'h0000_0010);
        rdc(IDX_SUMMARY, 32'h0000_0000);
        wr(IDX_CTRL, 32'h0000_0693);
        pulse(4, 6);
        rdc(IDX_SUMMARY, 32'h0000_0000);
        chkb(1'b1, relay_o);
        rdc(IDX_IMAGE, 32'h0000_0010);
        $display("test detail scanner done");

        wr(IDX_DELAY0 + 6'h06, 32'h0000_0002);
        rdc(IDX_DELAY0 + 6'h06, 32'h0000_0002);
        for (int i = 0; i < 2; i++)
        begin
            setc(6, 1'b1);
            repeat (12) @(posedge clk_i);
            rdc(IDX_QUAL, 32'h0000_0000);
            setc(6, 1'b0);
            repeat (4) @(posedge clk_i);
        end
        rdc(IDX_IMAGE, 32'h0000_0000);
        setc(6, 1'b1);
        repeat (40) @(posedge clk_i);
        rdc(IDX_QUAL, 32'h0000_0040);
        setc(6, 1'b0);
        repeat (6) @(posedge clk_i);
        rdc(IDX_IMAGE, 32'h0000_0040);
        wr(IDX_DELAY0 + 6'h06, 32'h0000_FFFF);
        rdc(IDX_DELAY0 + 6'h06, 32'h0000_FD20);
        $display("test delay done");
        stop_test();
    end
endmodule
